// ---- bench/ssw_cpu_model.sv ----
// processor model toggling the watchdog activity line
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic drive,
    output logic kick
);
int n = 0;
initial kick = 1'b0;
always @(negedge clk)
    n <= (n > 999 || !reset_n || !run) ? 0 : n + 1;
// a floating line wanders every cycle; the design must not take it as activity
always @(negedge clk)
    kick <= (!drive || n > 999) ? ~kick : kick;
endmodule
`default_nettype wire

// ---- bench/ssw_properties.sv ----
// assertion checker for the supply supervisor ports
`timescale 1ns/1ps
`default_nettype none
module ssw_props #(parameter [20:0] RESET_TICKS = 21'h14, parameter [20:0] WDOG_TICKS = 21'hA0)
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SUPPLY_LOW,
    input wire logic MANUAL_RESET_REQUEST_N,
    input wire logic ACTIVITY_KICK_IN,
    input wire logic ACTIVITY_KICK_DRIVEN,
    input wire logic POWERFAIL_SENSE_IN,
    input wire logic RESET_OUT_N,
    input wire logic TIMEOUT_FLAG_N,
    input wire logic POWERFAIL_FLAG_N
);
// tick phase is unknown, so periods get a margin of about one tick
localparam int LO = RESET_TICKS * 125 - 130;
localparam int HI = RESET_TICKS * 125 + 130;
localparam int WLO = WDOG_TICKS * 125 - 130;
int q = 0;
int k = 0;
logic kp = 1'b0;
// cycles since a reset cause ended, and since the last usable kick edge
always @(posedge MCLK)
begin
    q <= (RST || SUPPLY_LOW || !MANUAL_RESET_REQUEST_N || RESET_OUT_N) ? 0 : q + 1;
    k <= (RST || ACTIVITY_KICK_IN != kp || !ACTIVITY_KICK_DRIVEN || !RESET_OUT_N) ? 0 : k + 1;
    kp <= ACTIVITY_KICK_IN;
end
default clocking @(posedge MCLK); endclocking
default disable iff (RST);
property p_sup; SUPPLY_LOW |=> !RESET_OUT_N; endproperty
a_sup: assert property (p_sup) else $error("no reset on low supply");
property p_flg; SUPPLY_LOW |=> !TIMEOUT_FLAG_N; endproperty
a_flg: assert property (p_flg) else $error("flag high on low supply");
property p_mr; !MANUAL_RESET_REQUEST_N |=> !RESET_OUT_N; endproperty
a_mr: assert property (p_mr) else $error("no manual reset");
property p_min; $rose(RESET_OUT_N) |-> q >= LO; endproperty
a_min: assert property (p_min) else $error("reset too short");
property p_max; q <= HI; endproperty
a_max: assert property (p_max) else $error("reset too long");
property p_pf; 1 |=> POWERFAIL_FLAG_N == !$past(POWERFAIL_SENSE_IN); endproperty
a_pf: assert property (p_pf) else $error("power-fail flag wrong");
property p_fire; $fell(TIMEOUT_FLAG_N) |-> $past(SUPPLY_LOW) || k >= WLO; endproperty
a_fire: assert property (p_fire) else $error("early timeout");
property p_rise; $rose(TIMEOUT_FLAG_N) |-> $past(SUPPLY_LOW, 2) || k < 4; endproperty
a_rise: assert property (p_rise) else $error("flag rose without cause");
endmodule
bind ssw_supervisor ssw_props #(.RESET_TICKS(RESET_TICKS), .WDOG_TICKS(WDOG_TICKS)) i_ssw_props
    (.MCLK(MCLK), .RST(RST), .SUPPLY_LOW(SUPPLY_LOW), .ACTIVITY_KICK_IN(ACTIVITY_KICK_IN),
    .MANUAL_RESET_REQUEST_N(MANUAL_RESET_REQUEST_N), .ACTIVITY_KICK_DRIVEN(ACTIVITY_KICK_DRIVEN),
    .POWERFAIL_SENSE_IN(POWERFAIL_SENSE_IN), .RESET_OUT_N(RESET_OUT_N),
    .TIMEOUT_FLAG_N(TIMEOUT_FLAG_N), .POWERFAIL_FLAG_N(POWERFAIL_FLAG_N));
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
localparam int RT = 20 * 125;
localparam int WD = 160 * 125;
logic mclk = 0, rst = 1, sl = 1, mr_n = 1, tie = 0, sense = 0, run = 0, drive = 1;
wire kick, ro, ro_n, wf_n, pf_n;
wire mr_pin_n = mr_n & (wf_n | ~tie);
int bad_count = 0, n_tests = 0, n;
ssw_supervisor #(.RESET_TICKS(21'h14), .WDOG_TICKS(21'hA0)) i_ssw_supervisor (.MCLK(mclk),
    .RST(rst), .SUPPLY_LOW(sl), .MANUAL_RESET_REQUEST_N(mr_pin_n), .ACTIVITY_KICK_IN(kick),
    .ACTIVITY_KICK_DRIVEN(drive), .POWERFAIL_SENSE_IN(sense), .RESET_OUT(ro),
    .RESET_OUT_N(ro_n), .TIMEOUT_FLAG_N(wf_n), .POWERFAIL_FLAG_N(pf_n));
ssw_cpu_model i_ssw_cpu_model (.clk(mclk), .reset_n(ro_n), .run(run), .drive(drive), .kick(kick));
task bad(input logic [31:0] got, input logic [31:0] exp);
    bad_count++;
    $display("ERROR %0t got %h exp %h", $time, got, exp);
endtask
task chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
        bad(got, exp);
endtask
task chk_n(input int lo, input int hi);
    n_tests++;
    if (n < lo || n > hi)
        bad(n, lo);
endtask
task cyc(input int c);
    repeat (c) @(negedge mclk);
endtask
// bounded wait on the flag (sel 1) or the reset output (sel 0)
task wait_for(input logic sel, input logic want, input int lim);
    n = 0;
    while ((sel ? wf_n : ro_n) !== want && n < lim)
    begin
        cyc(1);
        n++;
    end
endtask
task t_power;
    cyc(20);
    chk(ro_n, 0);
    chk(ro, 0);
    chk(wf_n, 0);
    sl = 0;
    wait_for(0, 1, 4000);
    chk_n(RT - 130, RT + 130);
    sense = 1;
    cyc(2);
    chk(pf_n, 0);
endtask
task t_brown;
    mr_n = 0;
    cyc(2);
    chk(ro_n, 0);
    mr_n = 1;
    wait_for(0, 1, 4000);
    chk_n(RT - 130, RT + 130);
    sl = 1;
    cyc(2);
    chk(ro_n, 0);
    sl = 0;
    cyc(2);
    chk(wf_n, 1);
    cyc(1000);
    sl = 1;
    cyc(2);
    sl = 0;
    wait_for(0, 1, 4000);
    chk_n(RT - 130, RT + 130);
endtask
task t_wdog;
    run = 1;
    wait_for(1, 0, 25000);
    chk_n(25000, 25000);
    drive = 0;
    wait_for(1, 0, 22000);
    chk_n(22000, 22000);
    drive = 1;
    cyc(2000);
    run = 0;
    wait_for(1, 0, 30000);
    chk_n(WD - 1200, WD + 200);
    cyc(200);
    chk(wf_n, 0);
    tie = 1;
    cyc(3);
    chk(ro_n, 0);
    tie = 0;
    wait_for(0, 1, 4000);
    run = 1;
    wait_for(1, 1, 1500);
    chk_n(900, 1200);
endtask
task print_verdict;
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
initial
    forever #4 mclk = ~mclk;
initial
begin
    cyc(2);
    rst = 0;
    t_power;
    t_brown;
    t_wdog;
    print_verdict;
end
// the tests need about 80k cycles
initial
begin
    #800000;
    bad_count++;
    print_verdict;
end
endmodule
`default_nettype wire

// ---- rtl/ssw_defines.vh ----
// timing constants, output option codes and state codes for the supply supervisor
`ifndef SSW_DEFINES_VH
`define SSW_DEFINES_VH

// clock rate
`define SSW_CLK_HZ 125000000
// time base tick of 1 us, 125 cycles of the 125 MHz clock
`define SSW_TICK_US 1
`define SSW_TICK_CYC 7'h7D
`define SSW_TICK_W 7

// reset period 200 ms, in microsecond ticks
`define SSW_RESET_MS 200
`define SSW_RESET_TICKS 21'h030D40
// least manual reset pulse 140 ms, in microsecond ticks
`define SSW_MANUAL_MIN_MS 140
`define SSW_MANUAL_MIN_TICKS 21'h0222E0
// watchdog timeout 1600 ms, in microsecond ticks
`define SSW_WDOG_MS 1600
`define SSW_WDOG_TICKS 21'h186A00
`define SSW_CNT_W 21

// reset output option
`define SSW_OPT_HIGH 2'h0
`define SSW_OPT_LOW 2'h1
`define SSW_OPT_BOTH 2'h2

// reset sequencer states
`define SSW_ST_HOLD 2'h0
`define SSW_ST_DELAY 2'h1
`define SSW_ST_RUN 2'h2

`endif

// ---- rtl/ssw_supervisor.v ----
// supply supervisor: power-on and brownout reset, manual reset, watchdog (not in the SSW_OPT_BOTH build), power-fail flag
`timescale 1ns/1ps
`default_nettype none
`include "ssw_defines.vh"

module ssw_supervisor
#(
    parameter [1:0] RESET_OPTION = `SSW_OPT_LOW,
    parameter [20:0] RESET_TICKS = `SSW_RESET_TICKS,
    parameter [20:0] WDOG_TICKS = `SSW_WDOG_TICKS
)
(
    input wire MCLK,
    input wire RST,
    input wire SUPPLY_LOW,
    input wire MANUAL_RESET_REQUEST_N,
    input wire ACTIVITY_KICK_IN,
    input wire ACTIVITY_KICK_DRIVEN,
    input wire POWERFAIL_SENSE_IN,
    output reg RESET_OUT,
    output reg RESET_OUT_N,
    output reg TIMEOUT_FLAG_N,
    output reg POWERFAIL_FLAG_N
);

    ////////////////////////////////////////////////////////////////////////////

    localparam [6:0] TICK_LAST = `SSW_TICK_CYC - 7'h01;
    localparam HAS_WDOG = (RESET_OPTION != `SSW_OPT_BOTH);

    reg [6:0] prescale;
    reg tick;
    reg [1:0] state;
    reg [1:0] next_state;
    reg manual_prev;
    reg kick_prev;
    reg kick_valid;
    reg wdog_armed;
    reg wdog_fired;
    reg reset_level;
    wire manual_fall;
    wire kick_edge;
    wire reset_load;
    wire reset_expired;
    wire wdog_clear;
    wire wdog_load;
    wire wdog_expired;
    wire [20:0] reset_count;
    wire [20:0] wdog_count;
    wire wdog_timeout;

    ////////////////////////////////////////////////////////////////////////////
    // shared decoding

    // the timer rests at zero when idle, so only an armed zero is a timeout
    function timeout_due;
        input armed;
        input cleared;
        input expired;
        input reloading;
        begin
            timeout_due = armed && !cleared && expired && !reloading;
        end
    endfunction

    // drive level of one reset pin for the build option; an unused pin is parked inactive
    function reset_pin;
        input [1:0] option;
        input active_high;
        input level;
        begin
            if (active_high)
            begin
                reset_pin = (option == `SSW_OPT_LOW) ? 1'b0 : level;
            end
            else
            begin
                reset_pin = (option == `SSW_OPT_HIGH) ? 1'b1 : !level;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // free-running microsecond time base

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            prescale <= 7'h00;
        end
        else if (prescale == TICK_LAST)
        begin
            prescale <= 7'h00;
        end
        else
        begin
            prescale <= prescale + 7'h01;
        end
    end

    // one-cycle enable: the timers stay on the single clock, no derived clock
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            tick <= 1'b0;
        end
        else
        begin
            tick <= (prescale == TICK_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencer

    assign manual_fall = manual_prev && !MANUAL_RESET_REQUEST_N;
    // a request held low keeps reloading, so a bouncing switch yields one long pulse
    assign reset_load = SUPPLY_LOW || !MANUAL_RESET_REQUEST_N || manual_fall;

    ssw_timer u_reset_timer
    (
        .clk(MCLK),
        .rst(RST),
        .tick(tick),
        .clear(1'b0),
        .load(reset_load),
        .load_value(RESET_TICKS),
        .count(reset_count),
        .expired(reset_expired)
    );

    always @*
    begin
        next_state = state;
        case (state)
            `SSW_ST_HOLD:
            begin
                if (!reset_load)
                begin
                    next_state = `SSW_ST_DELAY;
                end
            end
            `SSW_ST_DELAY:
            begin
                if (reset_load)
                begin
                    next_state = `SSW_ST_HOLD;
                end
                else if (reset_expired)
                begin
                    next_state = `SSW_ST_RUN;
                end
            end
            `SSW_ST_RUN:
            begin
                if (reset_load)
                begin
                    next_state = `SSW_ST_HOLD;
                end
            end
            default:
            begin
                next_state = `SSW_ST_HOLD;
            end
        endcase
    end

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state <= `SSW_ST_HOLD;
            manual_prev <= 1'b1;
        end
        else
        begin
            state <= next_state;
            manual_prev <= MANUAL_RESET_REQUEST_N;
        end
    end

    // brownout and manual request act at once, not a cycle later
    always @*
    begin
        reset_level = (state != `SSW_ST_RUN) || reset_load;
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog

    // an undriven input has no meaningful level, so edges are only taken while driven
    assign kick_edge = ACTIVITY_KICK_DRIVEN && kick_valid && (ACTIVITY_KICK_IN != kick_prev);
    assign wdog_clear = !HAS_WDOG || reset_level || !ACTIVITY_KICK_DRIVEN;
    assign wdog_load = kick_edge;

    ssw_timer u_wdog_timer
    (
        .clk(MCLK),
        .rst(RST),
        .tick(tick),
        .clear(wdog_clear),
        .load(wdog_load),
        .load_value(WDOG_TICKS),
        .count(wdog_count),
        .expired(wdog_expired)
    );

    assign wdog_timeout = timeout_due(wdog_armed, wdog_clear, wdog_expired, wdog_load);

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            kick_prev <= 1'b0;
            kick_valid <= 1'b0;
        end
        else
        begin
            kick_prev <= ACTIVITY_KICK_IN;
            kick_valid <= ACTIVITY_KICK_DRIVEN;
        end
    end

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            wdog_armed <= 1'b0;
        end
        else if (wdog_clear)
        begin
            wdog_armed <= 1'b0;
        end
        else if (kick_edge)
        begin
            wdog_armed <= 1'b1;
        end
    end

    // an edge lifts the flag even while reset holds, so a kick after a forced reset frees it
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            wdog_fired <= 1'b0;
        end
        else if (kick_edge || !HAS_WDOG)
        begin
            wdog_fired <= 1'b0;
        end
        else if (wdog_timeout)
        begin
            wdog_fired <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    // one flop per pin; the build option also sets HAS_WDOG, which gates the timeout flag
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            RESET_OUT <= (RESET_OPTION == `SSW_OPT_LOW) ? 1'b0 : 1'b1;
        end
        else
        begin
            RESET_OUT <= reset_pin(RESET_OPTION, 1'b1, reset_level);
        end
    end

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            RESET_OUT_N <= (RESET_OPTION == `SSW_OPT_HIGH) ? 1'b1 : 1'b0;
        end
        else
        begin
            RESET_OUT_N <= reset_pin(RESET_OPTION, 1'b0, reset_level);
        end
    end

    // no release delay here: the flag follows the supply at once, unlike the reset pins
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            TIMEOUT_FLAG_N <= 1'b0;
        end
        else
        begin
            TIMEOUT_FLAG_N <= !(SUPPLY_LOW ||
                (HAS_WDOG && (wdog_fired || wdog_timeout)));
        end
    end

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            POWERFAIL_FLAG_N <= 1'b0;
        end
        else
        begin
            POWERFAIL_FLAG_N <= !POWERFAIL_SENSE_IN;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/ssw_timer.v ----
// down counter with load and clear, stepped by the time base tick
`timescale 1ns/1ps
`default_nettype none

module ssw_timer
(
    input wire clk,
    input wire rst,
    input wire tick,
    input wire clear,
    input wire load,
    input wire [20:0] load_value,
    output reg [20:0] count,
    output wire expired
);

    assign expired = (count == 21'h000000);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count <= 21'h000000;
        end
        else if (clear)
        begin
            count <= 21'h000000;
        end
        else if (load)
        begin
            count <= load_value;
        end
        else if (tick && count != 21'h000000)
        begin
            count <= count - 21'h000001;
        end
    end

endmodule

`default_nettype wire
